// ### dv/cwp_config_decode_assertions.sv
`timescale 1ns/1ps
module cwp_config_decode_assertions
(
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        devReset,
	input wire logic [21:0] cfgAddr,
	input wire logic        cfgWrEn,
	input wire logic        bulkErase,
	input wire logic        cfgWrDone,
	input wire logic        cfgWrRefused,
	input wire logic [1:0]  wdClkSel,
	input wire logic        wdClkIgnored,
	input wire logic [2:0]  wdWindowSel,
	input wire logic [3:0]  wdWindowOpenEighths,
	input wire logic        wdWindowSoftCtl,
	input wire logic        wdWindowKeyReq,
	input wire logic        appWriteProt,
	input wire logic        bootEnabled,
	input wire logic [15:0] bootSizeWords,
	input wire logic [15:0] bootEndAddr,
	input wire logic        lowVoltProgEn,
	input wire logic        resetPinIsReset,
	input wire logic        highVoltProgReq,
	input wire logic        codeProtect,
	input wire logic [7:0]  extMemRdData,
	input wire logic [7:0]  extRdData
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);

	// ========================================
	// write handshake
	sequence s_wrTaken;
		cfgWrEn && !bulkErase && cfgAddr >= cwp_pkg::CWP_OFS_WDCW
			&& cfgAddr <= cwp_pkg::CWP_OFS_SPARE;
	endsequence
	property p_wrAns;
		s_wrTaken |=> cfgWrDone || cfgWrRefused;
	endproperty
	a_wrAns: assert property (p_wrAns) else $error("write unanswered");

	// ========================================
	// decoded fields
	property p_clkIgn;
		wdClkIgnored |-> wdClkSel == 2'h0;
	endproperty
	a_clkIgn: assert property (p_clkIgn) else $error("clock not ignored");
	property p_window;
		wdWindowOpenEighths == (wdWindowSel > 3'h5 ? 4'h8
			: {1'b0, wdWindowSel} + 4'h1) && wdWindowKeyReq == !wdWindowSoftCtl;
	endproperty
	a_window: assert property (p_window) else $error("window decode");
	property p_bootOff;
		!bootEnabled |-> bootSizeWords == 16'h0 && bootEndAddr == 16'h0;
	endproperty
	a_bootOff: assert property (p_bootOff) else $error("boot size");
	property p_bootEnd;
		bootEnabled |-> bootSizeWords <= 16'h4000
			&& bootEndAddr == {bootSizeWords[14:0], 1'b0} - 16'h1;
	endproperty
	a_bootEnd: assert property (p_bootEnd) else $error("boot end");
	property p_lvp;
		lowVoltProgEn |-> resetPinIsReset && !highVoltProgReq;
	endproperty
	a_lvp: assert property (p_lvp) else $error("low voltage pin");
	// registered reader path, zero under protection
	property p_ext;
		$past(resetn) |-> extRdData ==
			($past(codeProtect) ? 8'h00 : $past(extMemRdData));
	endproperty
	a_ext: assert property (p_ext) else $error("external read");
	// latched copy only moves after a reload or reset release
	property p_hold;
		$past(resetn, 2) && $past(resetn, 3) && !$past(devReset)
			&& !$past(devReset, 2) && !$past(devReset, 3)
			|-> $stable(appWriteProt) && $stable(codeProtect)
			&& $stable(bootSizeWords) && $stable(wdWindowSel);
	endproperty
	a_hold: assert property (p_hold) else $error("decode moved");
endmodule

bind cwp_config_decode cwp_config_decode_assertions chk (.clock, .resetn,
	.devReset, .cfgAddr, .cfgWrEn, .bulkErase, .cfgWrDone, .cfgWrRefused,
	.wdClkSel, .wdClkIgnored, .wdWindowSel, .wdWindowOpenEighths,
	.wdWindowSoftCtl, .wdWindowKeyReq, .appWriteProt, .bootEnabled,
	.bootSizeWords, .bootEndAddr, .lowVoltProgEn, .resetPinIsReset,
	.highVoltProgReq, .codeProtect, .extMemRdData, .extRdData);

// ### dv/cwp_prog_model.sv
`timescale 1ns/1ps
module cwp_prog_model
(
	input  wire logic        clock,
	input  wire logic [7:0]  cfgRdData,
	input  wire logic        cfgWrDone,
	input  wire logic        cfgWrRefused,
	output logic      [21:0] cfgAddr,
	output logic             cfgWrEn,
	output logic      [7:0]  cfgWrData,
	output logic             cfgRdEn,
	output logic             bulkErase
);
	// programmer idles with all strobes low
	initial
	begin
		cfgAddr = 22'h0;
		cfgWrEn = 1'b0;
		cfgWrData = 8'h0;
		cfgRdEn = 1'b0;
		bulkErase = 1'b0;
	end
	// one byte a write; sticky bits are only ever written whole bytes
	task automatic wr(input logic [21:0] a, input logic [7:0] d,
		output logic [1:0] ans);
		@(negedge clock);
		cfgAddr = a;
		cfgWrData = d;
		cfgWrEn = 1'b1;
		@(negedge clock);
		cfgWrEn = 1'b0;
		cfgWrData = ~d; // no stale data once released
		ans = {cfgWrDone, cfgWrRefused};
	endtask
	task automatic rd(input logic [21:0] a, output logic [7:0] d);
		@(negedge clock);
		cfgAddr = a;
		cfgRdEn = 1'b1;
		@(negedge clock);
		cfgRdEn = 1'b0;
		d = cfgRdData;
	endtask
	// only way back to unprotected
	task automatic erase();
		@(negedge clock);
		bulkErase = 1'b1;
		@(negedge clock);
		bulkErase = 1'b0;
	endtask
endmodule

// ### dv/test_config_word_protection_decode.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("ERROR %s exp %h got %h", n, e, g); end end
module test_config_word_protection_decode;
	logic clock = 1'b0;
	logic resetn, devReset, cfgWrEn, cfgRdEn, bulkErase, lowVoltProgActive;
	logic resetPinEnable, cfgWrRefused, cfgWrDone, wdClkIgnored, codeProtect;
	logic wdWindowSoftCtl, appWriteProt, safEnabled, safWriteProt, bootEnabled;
	logic bootWriteProt, eeWriteProt, cfgWriteProt, lowVoltProgEn;
	logic resetPinIsReset, highVoltProgReq, wdWindowKeyReq, extWriteAllow;
	logic [21:0] cfgAddr;
	logic [1:0]  watchdogModeSel, ans;
	logic [7:0]  cfgWrData, cfgRdData, extMemRdData, extRdData, rd;
	logic [2:0]  wdWindowSel;
	logic [3:0]  wdWindowOpenEighths;
	logic [15:0] bootSizeWords, bootEndAddr;
	cwp_pkg::cwp_wdclk_e wdClkSel;
	int          fails = 0, n_tests = 0, cycles = 0, i;
	localparam logic [1:0] CLK_EXP [8] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0,
		2'h0, 2'h0, 2'h3};

	always #2 clock = ~clock;

	cwp_config_decode uut (.clock, .resetn, .devReset, .cfgAddr, .cfgWrEn,
		.cfgWrData, .cfgRdEn, .bulkErase, .lowVoltProgActive, .watchdogModeSel,
		.resetPinEnable, .extMemRdData, .cfgRdData, .cfgWrRefused, .cfgWrDone,
		.wdClkSel, .wdClkIgnored, .wdWindowSel, .wdWindowOpenEighths,
		.wdWindowSoftCtl, .wdWindowKeyReq, .appWriteProt, .safEnabled,
		.safWriteProt, .bootEnabled, .bootSizeWords, .bootEndAddr,
		.bootWriteProt, .eeWriteProt, .cfgWriteProt, .lowVoltProgEn,
		.resetPinIsReset, .highVoltProgReq, .codeProtect, .extWriteAllow,
		.extRdData);
	cwp_prog_model prog (.clock, .cfgRdData, .cfgWrDone, .cfgWrRefused,
		.cfgAddr, .cfgWrEn, .cfgWrData, .cfgRdEn, .bulkErase);

	// ========================================
	// helpers
	task test_done;
		$display("tests %0d errors %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// decoded copy settles two edges after the pulse
	task reload;
		@(negedge clock);
		devReset = 1'b1;
		@(negedge clock);
		devReset = 1'b0;
		repeat (2) @(negedge clock);
	endtask
	// hang guard, the sequence needs about 130 cycles
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			test_done;
		end
	end

	// ========================================
	// main sequence
	initial
	begin
		{devReset, lowVoltProgActive, resetn} = 3'b000;
		watchdogModeSel = 2'h3;
		resetPinEnable = 1'b1;
		extMemRdData = 8'h5a;
		repeat (10) @(negedge clock);
		resetn = 1'b1;
		for (i = 0; i < 5; i++)
		begin
			prog.rd(cwp_pkg::CWP_OFS_WDCW + 22'(i), rd);
			`CHK("blank", 8'hff, rd)
		end
		prog.rd(22'h300004, rd);
		`CHK("unmapped", 8'hff, rd)
		`CHK("blankClk", 2'h3, wdClkSel)
		`CHK("blankBoot", 1'b0, bootEnabled)
		`CHK("blankExt", 8'h5a, extRdData)
		// every clock and window code
		for (i = 0; i < 8; i++)
		begin
			prog.wr(cwp_pkg::CWP_OFS_WDCW, {2'b00, 3'(i), 3'(i)}, ans);
			`CHK("wdAns", 2'b10, ans)
			prog.rd(cwp_pkg::CWP_OFS_WDCW, rd);
			`CHK("wdByte", {2'b11, 3'(i), 3'(i)}, rd)
			reload;
			`CHK("wdClk", CLK_EXP[i], wdClkSel)
			`CHK("wdWin", (i > 5) ? 3'h7 : 3'(i), wdWindowSel)
			`CHK("wdOpen", (i > 5) ? 4'h8 : 4'(i + 1), wdWindowOpenEighths)
			`CHK("wdSoft", i == 7, wdWindowSoftCtl)
			`CHK("wdKey", i != 7, wdWindowKeyReq)
		end
		watchdogModeSel = 2'h0;
		reload;
		`CHK("wdIgn", 1'b1, wdClkIgnored)
		`CHK("wdIgnClk", 2'h0, wdClkSel)
		// boot block at size code 000, then try to undo it
		prog.wr(cwp_pkg::CWP_OFS_PART, 8'h00, ans);
		`CHK("partAns", 2'b10, ans)
		prog.wr(cwp_pkg::CWP_OFS_PART, 8'hff, ans);
		`CHK("partKeep", 2'b11, ans)
		prog.rd(cwp_pkg::CWP_OFS_PART, rd);
		`CHK("partByte", 8'h60, rd)
		prog.wr(cwp_pkg::CWP_OFS_CP, 8'h00, ans);
		prog.rd(cwp_pkg::CWP_OFS_CP, rd);
		`CHK("cpByte", 8'hfe, rd)
		lowVoltProgActive = 1'b1;
		prog.wr(cwp_pkg::CWP_OFS_WP, 8'h00, ans);
		lowVoltProgActive = 1'b0;
		`CHK("lvpKeep", 2'b11, ans)
		prog.rd(cwp_pkg::CWP_OFS_WP, rd);
		`CHK("wpByte", 8'hf0, rd)
		reload;
		`CHK("bootOn", 1'b1, bootEnabled)
		`CHK("bootCap", 16'h4000, bootSizeWords)
		`CHK("bootEnd", 16'h7fff, bootEndAddr)
		`CHK("appWp", 1'b1, appWriteProt)
		`CHK("storage_area_enable_n", 1'b1, safEnabled)
		`CHK("safWp", 1'b1, safWriteProt)
		`CHK("eeWp", 1'b1, eeWriteProt)
		`CHK("cfgWp", 1'b1, cfgWriteProt)
		`CHK("bootWp", 1'b1, bootWriteProt)
		`CHK("cp", 1'b1, codeProtect)
		`CHK("cpExt", 8'h00, extRdData)
		`CHK("cpWrAllow", 1'b0, extWriteAllow)
		prog.wr(cwp_pkg::CWP_OFS_WDCW, 8'h00, ans);
		`CHK("cfgLock", 2'b01, ans)
		prog.rd(cwp_pkg::CWP_OFS_WDCW, rd);
		`CHK("cfgLockByte", 8'hff, rd)
		// bulk erase, then leave low-voltage mode from high voltage
		prog.erase();
		prog.rd(cwp_pkg::CWP_OFS_PART, rd);
		`CHK("erased", 8'hff, rd)
		// pin enable off while low-voltage bit set: reset function still forced
		resetPinEnable = 1'b0;
		reload;
		`CHK("lvpOn", 1'b1, lowVoltProgEn)
		`CHK("pinForced", 1'b1, resetPinIsReset)
		`CHK("wrAllow", 1'b1, extWriteAllow)
		prog.wr(cwp_pkg::CWP_OFS_WP, 8'hdf, ans);
		`CHK("lvpClr", 2'b10, ans)
		reload;
		`CHK("lvpOff", 1'b0, lowVoltProgEn)
		`CHK("hvReq", 1'b1, highVoltProgReq)
		`CHK("pinPort", 1'b0, resetPinIsReset)
		`CHK("cpOff", 1'b0, codeProtect)
		test_done;
	end
endmodule

// ### hw/cwp_boot_block.sv
`timescale 1ns/1ps
module cwp_boot_block
(
	input  wire logic       bootBlockEnableN,
	input  wire logic [2:0] bootBlockSizeSel,
	output logic      [15:0] bootSizeWords,
	output logic      [15:0] bootEndAddr,
	output logic             bootEnabled
);
	// ========================================
	// size from code
	// codes at or below the largest step all map to the largest size
	logic [2:0]  shiftAmt;
	logic [16:0] rawWords;
	logic [16:0] capWords;
	logic [16:0] sizeWords;

	assign shiftAmt = (bootBlockSizeSel <= cwp_pkg::CWP_BBSZ_MAX_CODE)
		? 3'(cwp_pkg::CWP_BBSZ_MIN_CODE - cwp_pkg::CWP_BBSZ_MAX_CODE)
		: 3'(cwp_pkg::CWP_BBSZ_MIN_CODE - bootBlockSizeSel);
	assign rawWords = cwp_pkg::CWP_BBSZ_MIN << shiftAmt; // [R8]
	// half the program flash is the largest boot block allowed
	assign capWords = cwp_pkg::CWP_PFM_WORDS >> 1;
	assign sizeWords = (rawWords > capWords) ? capWords : rawWords; // [R9]

	// ========================================
	// disabled boot block has no size at all
	assign bootEnabled = ~bootBlockEnableN; // [R7]
	assign bootSizeWords = bootEnabled ? sizeWords[15:0] : 16'h0000; // [R7]
	// end is a byte address: two bytes per word
	assign bootEndAddr = bootEnabled
		? 16'({sizeWords[15:0], 1'b0} - 17'h00001) : 16'h0000;
endmodule

// ### hw/cwp_config_decode.sv
`timescale 1ns/1ps
module cwp_config_decode
(
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        devReset,
	input  wire logic [21:0] cfgAddr,
	input  wire logic        cfgWrEn,
	input  wire logic [7:0]  cfgWrData,
	input  wire logic        cfgRdEn,
	input  wire logic        bulkErase,
	input  wire logic        lowVoltProgActive,
	input  wire logic [1:0]  watchdogModeSel,
	input  wire logic        resetPinEnable,
	input  wire logic [7:0]  extMemRdData,
	output logic      [7:0]  cfgRdData,
	output logic             cfgWrRefused,
	output logic             cfgWrDone,
	output cwp_pkg::cwp_wdclk_e wdClkSel,
	output logic             wdClkIgnored,
	output logic      [2:0]  wdWindowSel,
	output logic      [3:0]  wdWindowOpenEighths,
	output logic             wdWindowSoftCtl,
	output logic             wdWindowKeyReq,
	output logic             appWriteProt,
	output logic             safEnabled,
	output logic             safWriteProt,
	output logic             bootEnabled,
	output logic      [15:0] bootSizeWords,
	output logic      [15:0] bootEndAddr,
	output logic             bootWriteProt,
	output logic             eeWriteProt,
	output logic             cfgWriteProt,
	output logic             lowVoltProgEn,
	output logic             resetPinIsReset,
	output logic             highVoltProgReq,
	output logic             codeProtect,
	output logic             extWriteAllow,
	output logic      [7:0]  extRdData
);
	// ========================================
	// storage and latched copies
	logic [7:0] cfgMem_r [cwp_pkg::CWP_NUM_BYTES];
	logic [7:0] cfgLat_r [cwp_pkg::CWP_NUM_BYTES];
	logic       loadPend_r;
	logic [1:0] wdModeLat_r;
	logic       rstPinEnLat_r;
	logic [7:0] rdData_r;
	logic       wrRefused_r;
	logic       wrDone_r;
	logic [7:0] extRd_r;

	// ========================================
	// address decode
	wire        addrHit;
	wire [21:0] addrOff;
	wire [2:0]  wrIdx;
	wire [7:0]  oldByte;

	assign addrHit = (cfgAddr >= cwp_pkg::CWP_OFS_WDCW)
		&& (cfgAddr <= cwp_pkg::CWP_OFS_SPARE);
	assign addrOff = cfgAddr - cwp_pkg::CWP_OFS_WDCW;
	assign wrIdx = addrHit ? addrOff[2:0] : 3'h0;
	assign oldByte = cfgMem_r[wrIdx];

	// ========================================
	// write merge
	// sticky bits can only be driven towards their protected state
	wire [7:0] stickyMask;
	wire [7:0] unimplMask;
	wire [7:0] genMerge;
	wire       keepSize;
	wire       keepLvp;
	wire [7:0] keepMask;
	wire [7:0] newByte;

	assign stickyMask = cwp_pkg::CWP_STICKY[wrIdx];
	assign unimplMask = cwp_pkg::CWP_UNIMPL[wrIdx];
	assign genMerge = (oldByte & cfgWrData & stickyMask) // [R10]
		| (cfgWrData & ~stickyMask & ~unimplMask)
		| unimplMask; // [R19]
	// size is frozen once the boot block has been enabled
	assign keepSize = (wrIdx == 3'(cwp_pkg::CWP_IDX_PART))
		&& !oldByte[cwp_pkg::CWP_BOOT_BLOCK_ENABLE_N_BIT]; // [R11]
	// low-voltage session must not drop itself out of that mode
	assign keepLvp = (wrIdx == 3'(cwp_pkg::CWP_IDX_WP))
		&& lowVoltProgActive
		&& !cfgWrData[cwp_pkg::CWP_LVP_BIT]; // [R13]
	assign keepMask = (keepSize ? cwp_pkg::CWP_BBSZ_MASK : 8'h00)
		| (keepLvp ? cwp_pkg::CWP_LVP_MASK : 8'h00);
	assign newByte = (genMerge & ~keepMask) | (oldByte & keepMask);

	// ========================================
	// write acceptance
	// protection uses the live stored bit so a lock takes hold at once
	wire cfgLocked;
	wire wrHit;
	wire wrAccept;
	wire wrPartial;

	assign cfgLocked = !cfgMem_r[cwp_pkg::CWP_IDX_WP][cwp_pkg::CWP_CFGWP_BIT];
	assign wrHit = cfgWrEn && addrHit && !bulkErase;
	assign wrAccept = wrHit && !cfgLocked; // [R16]
	assign wrPartial = wrAccept && (keepSize || keepLvp);

	// ========================================
	// configuration bytes and their reset-time copies
	// storage starts blank; a real part keeps it across power cycles
	genvar gi;
	generate
		for (gi = 0; gi < cwp_pkg::CWP_NUM_BYTES; gi++)
		begin : g_byte
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					cfgMem_r[gi] <= cwp_pkg::CWP_BLANK; // [R19]
				else if (bulkErase)
					cfgMem_r[gi] <= cwp_pkg::CWP_BLANK; // [R10]
				else if (wrAccept && (wrIdx == 3'(gi)))
					cfgMem_r[gi] <= newByte;
			end

			// copy used by the decode; stable between device resets
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					cfgLat_r[gi] <= cwp_pkg::CWP_BLANK;
				else if (loadPend_r)
					cfgLat_r[gi] <= cfgMem_r[gi]; // [R21]
			end
		end
	endgenerate

	// ========================================
	// reload after power-on reset and on each device reset
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			loadPend_r <= 1'b1;
		else
			loadPend_r <= devReset; // [R21]
	end

	// lower-byte settings sampled together with the copies
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			wdModeLat_r <= cwp_pkg::CWP_WDMODE_RST;
			rstPinEnLat_r <= 1'b1;
		end
		else if (loadPend_r)
		begin
			wdModeLat_r <= watchdogModeSel; // [R21]
			rstPinEnLat_r <= resetPinEnable;
		end
	end

	// ========================================
	// read port and write status
	// addresses outside the block read as unimplemented ones
	wire [7:0] rdByte;

	assign rdByte = addrHit ? cfgMem_r[wrIdx] : cwp_pkg::CWP_BLANK; // [R19]

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rdData_r <= cwp_pkg::CWP_BLANK;
			wrRefused_r <= 1'b0;
			wrDone_r <= 1'b0;
		end
		else
		begin
			if (cfgRdEn)
				rdData_r <= rdByte;
			wrRefused_r <= (wrHit && cfgLocked) || wrPartial;
			wrDone_r <= wrAccept;
		end
	end

	assign cfgRdData = rdData_r;
	assign cfgWrRefused = wrRefused_r;
	assign cfgWrDone = wrDone_r;

	// ========================================
	// watchdog clock and window decode
	wire [7:0] wdcwByte;
	wire [2:0] ccsField;
	wire [2:0] cwsField;
	wire       wdOff;

	assign wdcwByte = cfgLat_r[cwp_pkg::CWP_IDX_WDCW];
	assign ccsField = wdcwByte[cwp_pkg::CWP_CCS_LSB +: 3];
	assign cwsField = wdcwByte[cwp_pkg::CWP_CWS_LSB +: 3];
	assign wdOff = (wdModeLat_r == cwp_pkg::CWP_WDMODE_OFF);

	// reserved codes fall to the low-frequency oscillator
	always_comb
	begin
		if (wdOff)
			wdClkSel = cwp_pkg::CWP_CLK_LFOSC; // [R1]
		else
		begin
			case (ccsField)
				cwp_pkg::CWP_CCS_LF:   wdClkSel = cwp_pkg::CWP_CLK_LFOSC; // [R2]
				cwp_pkg::CWP_CCS_MF:   wdClkSel = cwp_pkg::CWP_CLK_MFOSC; // [R2]
				cwp_pkg::CWP_CCS_SECONDARY_OSC: wdClkSel = cwp_pkg::CWP_CLK_SECOSC; // [R2]
				cwp_pkg::CWP_CCS_SW:   wdClkSel = cwp_pkg::CWP_CLK_SOFT; // [R3]
				default:               wdClkSel = cwp_pkg::CWP_CLK_LFOSC; // [R3]
			endcase
		end
	end

	assign wdClkIgnored = wdOff; // [R1]

	// 110 and 111 both load a fully open window
	assign wdWindowSel = (cwsField > cwp_pkg::CWP_CWS_LAST)
		? cwp_pkg::CWP_CWS_OPEN : cwsField; // [R4]
	assign wdWindowOpenEighths = (wdWindowSel == cwp_pkg::CWP_CWS_OPEN)
		? cwp_pkg::CWP_CWS_FULL8
		: 4'({1'b0, wdWindowSel} + 4'h1); // [R4]
	assign wdWindowSoftCtl = (cwsField == cwp_pkg::CWP_CWS_OPEN); // [R4]
	assign wdWindowKeyReq = (cwsField != cwp_pkg::CWP_CWS_OPEN); // [R4]

	// ========================================
	// memory partition decode
	wire [7:0] partByte;
	wire [7:0] wpByte;
	wire [7:0] cpByte;

	assign partByte = cfgLat_r[cwp_pkg::CWP_IDX_PART];
	assign wpByte = cfgLat_r[cwp_pkg::CWP_IDX_WP];
	assign cpByte = cfgLat_r[cwp_pkg::CWP_IDX_CP];

	assign appWriteProt = !partByte[cwp_pkg::CWP_APPWP_BIT]; // [R5]
	assign safEnabled = cwp_pkg::CWP_HAS_SAF
		&& !partByte[cwp_pkg::CWP_STORAGE_AREA_ENABLE_N_BIT]; // [R6]

	cwp_boot_block u_boot
	(
		.bootBlockEnableN (partByte[cwp_pkg::CWP_BOOT_BLOCK_ENABLE_N_BIT]),
		.bootBlockSizeSel (partByte[cwp_pkg::CWP_BBSZ_LSB +: 3]),
		.bootSizeWords    (bootSizeWords),
		.bootEndAddr      (bootEndAddr),
		.bootEnabled      (bootEnabled)
	);

	// ========================================
	// write-protect decode
	// region flags only count while the region itself is present
	assign safWriteProt = safEnabled
		&& !wpByte[cwp_pkg::CWP_SAFWP_BIT]; // [R14]
	assign eeWriteProt = cwp_pkg::CWP_HAS_EE
		&& !wpByte[cwp_pkg::CWP_EEWP_BIT]; // [R15]
	assign cfgWriteProt = !wpByte[cwp_pkg::CWP_CFGWP_BIT]; // [R16]
	assign bootWriteProt = bootEnabled
		&& !wpByte[cwp_pkg::CWP_BOOTWP_BIT]; // [R17]

	// ========================================
	// programming pin decode
	assign lowVoltProgEn = wpByte[cwp_pkg::CWP_LVP_BIT];
	assign resetPinIsReset = lowVoltProgEn || rstPinEnLat_r; // [R12]
	assign highVoltProgReq = !lowVoltProgEn; // [R12]

	// ========================================
	// code protection of external access
	// only the external path is gated; the processor path is untouched
	assign codeProtect = !cpByte[cwp_pkg::CWP_CP_BIT]; // [R18]
	assign extWriteAllow = !codeProtect; // [R20]

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			extRd_r <= 8'h00;
		else
			extRd_r <= codeProtect ? 8'h00 : extMemRdData; // [R20]
	end

	assign extRdData = extRd_r;
endmodule

// ### hw/cwp_pkg.sv
// Summary of operation
// R1 - watchdog mode 00 makes the watchdog clock selector ignored
// R2 - clock selector 000 low-freq osc, 001 mid-freq osc, 010 secondary osc
// R3 - selector 011..110 fall back to low-freq osc; 111 gives software control
// R4 - window 000..101 step 12.5 percent; 110/111 load 111, only 111 software
// R5 - application write-protect bit 0 blocks application block writes
// R6 - storage-area enable bit 0 enables region, 1 disables it
// R7 - boot enable bit 0 enables boot block; 1 forces size zero
// R8 - size 111 is 512 words, each lower code doubles; 001/000 give 32768
// R9 - boot block capped at half of program flash
// R10 - protection and enable bits only move to enabled until bulk erase
// R11 - boot size field changes only while boot enable bit is 1
// R12 - low-voltage bit 1 forces reset pin function; 0 needs high voltage
// R13 - low-voltage session refuses writes that clear the low-voltage bit
// R14 - storage write-protect 0 protects region, only if present and enabled
// R15 - data eeprom write-protect 0 blocks writes; absent without data eeprom
// R16 - configuration write-protect 0 blocks configuration byte writes
// R17 - boot write-protect 0 blocks boot writes, only while boot enabled
// R18 - code-protect bit 0 enables flash and eeprom code protection
// R19 - unimplemented bits and blank device bits read as 1
// R20 - code protection blocks external access, external reads return zero
// R21 - decoded fields latched at reset and held until next reset
package cwp_pkg;
	// ========================================
	// byte addresses of the configuration bytes
	localparam logic [21:0] CWP_OFS_WDCW  = 22'h300005;
	localparam logic [21:0] CWP_OFS_PART  = 22'h300006;
	localparam logic [21:0] CWP_OFS_WP    = 22'h300007;
	localparam logic [21:0] CWP_OFS_CP    = 22'h300008;
	localparam logic [21:0] CWP_OFS_SPARE = 22'h300009;
	localparam int          CWP_NUM_BYTES = 5;
	localparam int          CWP_IDX_WDCW  = 0;
	localparam int          CWP_IDX_PART  = 1;
	localparam int          CWP_IDX_WP    = 2;
	localparam int          CWP_IDX_CP    = 3;
	localparam int          CWP_IDX_SPARE = 4;

	// ========================================
	// device options
	localparam bit          CWP_HAS_SAF   = 1'b1;
	localparam bit          CWP_HAS_EE    = 1'b1;
	localparam logic [16:0] CWP_PFM_WORDS = 17'h08000;

	// ========================================
	// field positions
	localparam int CWP_CCS_LSB    = 3;
	localparam int CWP_CWS_LSB    = 0;
	localparam int CWP_APPWP_BIT  = 7;
	localparam int CWP_STORAGE_AREA_ENABLE_N_BIT  = 4;
	localparam int CWP_BOOT_BLOCK_ENABLE_N_BIT   = 3;
	localparam int CWP_BBSZ_LSB   = 0;
	localparam int CWP_LVP_BIT    = 5;
	localparam int CWP_SAFWP_BIT  = 3;
	localparam int CWP_EEWP_BIT   = 2;
	localparam int CWP_CFGWP_BIT  = 1;
	localparam int CWP_BOOTWP_BIT = 0;
	localparam int CWP_CP_BIT     = 0;

	// ========================================
	// reset values and byte masks
	localparam logic [7:0] CWP_BLANK     = 8'hff;
	localparam logic [1:0] CWP_WDMODE_RST = 2'h3;
	localparam logic [7:0] CWP_BBSZ_MASK = 8'h07;
	localparam logic [7:0] CWP_LVP_MASK  = 8'h20;
	localparam logic [7:0] CWP_UNIMPL [CWP_NUM_BYTES] = '{
		8'hc0,
		8'h60,
		8'hd0 | (CWP_HAS_SAF ? 8'h00 : 8'h08) | (CWP_HAS_EE ? 8'h00 : 8'h04),
		8'hfe,
		8'hff};
	localparam logic [7:0] CWP_STICKY [CWP_NUM_BYTES] = '{
		8'h00, 8'h98, 8'h0f, 8'h01, 8'h00};

	// ========================================
	// watchdog encodings
	localparam logic [1:0] CWP_WDMODE_OFF = 2'h0;
	localparam logic [2:0] CWP_CCS_LF     = 3'h0;
	localparam logic [2:0] CWP_CCS_MF     = 3'h1;
	localparam logic [2:0] CWP_CCS_SECONDARY_OSC   = 3'h2;
	localparam logic [2:0] CWP_CCS_SW     = 3'h7;
	localparam logic [2:0] CWP_CWS_LAST   = 3'h5;
	localparam logic [2:0] CWP_CWS_OPEN   = 3'h7;
	localparam logic [3:0] CWP_CWS_FULL8  = 4'h8;

	// ========================================
	// boot block sizes in words
	localparam logic [2:0]  CWP_BBSZ_MIN_CODE = 3'h7;
	localparam logic [2:0]  CWP_BBSZ_MAX_CODE = 3'h1;
	localparam logic [16:0] CWP_BBSZ_MIN      = 17'h00200;
	localparam logic [16:0] CWP_BBSZ_MAX      = 17'h08000;

	typedef enum logic [1:0] {
		CWP_CLK_LFOSC,
		CWP_CLK_MFOSC,
		CWP_CLK_SECOSC,
		CWP_CLK_SOFT
	} cwp_wdclk_e;
endpackage
